// *** rtl/assc_pkg.sv ***
// Package of constants and types for the serial sampling control block
package assc_pkg;

	// ****************************************************************
	// Frame and word layout
	// ****************************************************************
	localparam int WORD_BITS = 16;
	localparam int CMD_MSB = 15;
	localparam int CMD_LSB = 12;
	localparam int DATA_BITS = 12;
	localparam logic [4:0] EDGE_LIMIT = 5'h10;
	localparam logic [4:0] SAMPLE_START_EDGE = 5'h04;
	localparam logic [4:0] EDGE_CNT_RST = 5'h00;

	// ****************************************************************
	// Sampling and conversion timing, result FIFO and multiplexer
	// ****************************************************************
	localparam logic [4:0] SHORT_SAMPLE_SCLKS = 5'h0C;
	localparam logic [4:0] LONG_SAMPLE_SCLKS = 5'h18;
	localparam int CONV_SCLKS = 72;
	localparam int OSC_DIV = 4;
	localparam logic [6:0] CONV_CNT_RST = 7'h00;
	localparam logic [1:0] OSC_CNT_RST = 2'h0;
	localparam logic [11:0] RESULT_RST = 12'h000;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW = 3;
	localparam int MUX_CHANNELS = 8;
	localparam int SELF_TESTS = 3;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0]
	{
		ASSC_IDLE = 2'b00,
		ASSC_SAMPLE = 2'b01,
		ASSC_CONVERT = 2'b11
	} assc_state_e;

	typedef struct packed
	{
		logic long_sample;
		logic sclk_conv_clk;
		logic [3:0] channel;
	} assc_cfg_s;

	typedef struct packed
	{
		logic [3:0] cmd;
		logic [11:0] data;
	} assc_word_s;

endpackage

// *** rtl/assc_result_mem.sv ***
// Eight-entry result memory with registered read data
module assc_result_mem
(
	input wire logic clock,
	input wire logic we,
	input wire logic [assc_pkg::FIFO_AW-1:0] waddr,
	input wire logic [assc_pkg::DATA_BITS-1:0] wdata,
	input wire logic [assc_pkg::FIFO_AW-1:0] raddr,
	output logic [assc_pkg::DATA_BITS-1:0] rdata
);
	import assc_pkg::*;

	logic [DATA_BITS-1:0] mem [FIFO_DEPTH];

	always_ff @(posedge clock)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end

endmodule

// *** rtl/assc_top.sv ***
// Serial port front end and sampling/conversion start control
// Notes on behaviour
// - Chip select falling clears edge counter, unfloats output, enables input unless frame sync is low.
// - Input stops after sixteen edges or chip select rising.
// - Output floats after chip select rises.
// - Normal sampling begins after the fourth serial clock edge.
// - Normal sampling lasts 12 or 24 serial clocks, programmable.
// - Start pin falling begins sampling the selected channel.
// - Start pin rising holds the sample and begins conversion.
// - Extended sampling lasts exactly while start pin is low.
// - Start pin works without serial clock and with chip select high.
// - Conversion clock may come from the serial clock.
// - Built-in oscillator clocks conversion when serial clock not chosen.
// - Multiplexer selects any input or three self-test voltages.
// - Results are buffered in an eight-entry FIFO.
// - Words MSB first; top four bits command; twelve data bits.
// - Capture on rising clock, or falling clock when frame sync used.
// - Frame sync falling also clears counter and enables input.
// - Output gives 12 result bits, 4 zeros, then floats.
module assc_top
(
	input wire logic clock,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic serial_clk,
	input wire logic serial_in,
	input wire logic frame_sync,
	input wire logic conversion_start_n,
	input wire assc_pkg::assc_cfg_s cfg,
	input wire logic fifo_read,
	output logic serial_out_o,
	output logic serial_out_oe_n,
	output assc_pkg::assc_word_s word_out,
	output logic word_valid,
	output logic sampling,
	output logic converting,
	output logic [3:0] mux_select,
	output logic [assc_pkg::FIFO_AW:0] fifo_level
);
	import assc_pkg::*;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [1:0] cs_s1, cs_s2, sck_s1, sck_s2, fs_s1, fs_s2, cst_s1, cst_s2;
	logic sdi_s1, sdi_s2;
	logic cs_d, fs_d;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cs_s1 <= 2'h3;
			cs_s2 <= 2'h3;
			sck_s1 <= 2'h0;
			sck_s2 <= 2'h0;
			fs_s1 <= 2'h3;
			fs_s2 <= 2'h3;
			cst_s1 <= 2'h3;
			cst_s2 <= 2'h3;
			sdi_s1 <= 1'b0;
			sdi_s2 <= 1'b0;
		end
		else
		begin
			cs_s1 <= {cs_s1[0], chip_select_n};
			cs_s2 <= {cs_s2[0], cs_s1[1]};
			sck_s1 <= {sck_s1[0], serial_clk};
			sck_s2 <= {sck_s2[0], sck_s1[1]};
			fs_s1 <= {fs_s1[0], frame_sync};
			fs_s2 <= {fs_s2[0], fs_s1[1]};
			cst_s1 <= {cst_s1[0], conversion_start_n};
			cst_s2 <= {cst_s2[0], cst_s1[1]};
			sdi_s1 <= serial_in;
			sdi_s2 <= sdi_s1;
		end
	end

	// Stage [0] of each s1 is the first flop, [1] the second; s2 holds
	// synchronised value and its previous copy for edge detection.
	assign cs_d = cs_s2[0];
	assign fs_d = fs_s2[0];

	wire cs_fall = cs_s2[1] & ~cs_s2[0];
	wire cs_rise = ~cs_s2[1] & cs_s2[0];
	wire fs_fall = fs_s2[1] & ~fs_s2[0];
	wire sck_rise = ~sck_s2[1] & sck_s2[0];
	wire sck_fall = sck_s2[1] & ~sck_s2[0];
	wire cst_fall = cst_s2[1] & ~cst_s2[0];
	wire cst_rise = ~cst_s2[1] & cst_s2[0];

	// ****************************************************************
	// Frame control and edge counter
	// ****************************************************************
	logic fs_mode_reg, in_en_reg, frame_reg;
	logic [4:0] edge_cnt_reg;
	logic [15:0] shift_reg;

	// With frame sync in use, capture and shift on falling clock edges
	wire active_edge = fs_mode_reg ? sck_fall : sck_rise;
	wire frame_start = cs_fall | (fs_fall & ~cs_d);
	wire edge_take = in_en_reg & active_edge & ~cs_d;
	wire cnt_done = (edge_cnt_reg == EDGE_LIMIT);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			fs_mode_reg <= 1'b0;
			in_en_reg <= 1'b0;
			frame_reg <= 1'b0;
			edge_cnt_reg <= EDGE_CNT_RST;
			shift_reg <= 16'h0000;
		end
		else if (frame_start)
		begin
			// Frame sync low at chip select fall waits for its own edge
			fs_mode_reg <= cs_fall ? ~fs_d : 1'b1;
			in_en_reg <= cs_fall ? fs_d : 1'b1;
			frame_reg <= 1'b1;
			edge_cnt_reg <= EDGE_CNT_RST;
		end
		else if (cs_rise)
		begin
			in_en_reg <= 1'b0;
			frame_reg <= 1'b0;
		end
		else if (edge_take)
		begin
			shift_reg <= {shift_reg[14:0], sdi_s2};
			edge_cnt_reg <= edge_cnt_reg + 5'h01;
			if (edge_cnt_reg == EDGE_LIMIT - 5'h01)
				in_en_reg <= 1'b0;
		end
	end

	// Word strobe once the sixteenth bit has landed
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			word_valid <= 1'b0;
			word_out <= '0;
		end
		else
		begin
			word_valid <= edge_take & (edge_cnt_reg == EDGE_LIMIT - 5'h01);
			if (edge_take & (edge_cnt_reg == EDGE_LIMIT - 5'h01))
				word_out <= {shift_reg[14:0], sdi_s2};
		end
	end

	// ****************************************************************
	// Serial output
	// ****************************************************************
	logic [DATA_BITS-1:0] out_word_reg;
	logic [DATA_BITS-1:0] fifo_rdata;
	wire [15:0] out_frame = {out_word_reg, 4'h0};
	wire [3:0] out_idx = 4'hF - edge_cnt_reg[3:0];

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			serial_out_oe_n <= 1'b1;
			serial_out_o <= 1'b0;
		end
		else
		begin
			// Float once chip select rises or sixteen bits are out
			serial_out_oe_n <= ~frame_reg | cs_d | cnt_done;
			serial_out_o <= out_frame[out_idx];
		end
	end

	// ****************************************************************
	// Sampling and conversion
	// ****************************************************************
	assc_state_e state_reg, state_next;
	logic [4:0] samp_cnt_reg;
	logic [6:0] conv_cnt_reg;
	logic [1:0] osc_cnt_reg;
	logic ext_reg;
	logic [DATA_BITS-1:0] result_reg;

	wire normal_go = edge_take & (edge_cnt_reg == SAMPLE_START_EDGE - 5'h01);
	wire [4:0] samp_len = cfg.long_sample ? LONG_SAMPLE_SCLKS
		: SHORT_SAMPLE_SCLKS;
	wire internal_conv_oscillator = (osc_cnt_reg == OSC_DIV[1:0] - 2'h1);
	wire conv_tick = cfg.sclk_conv_clk ? sck_rise
		: internal_conv_oscillator;
	wire samp_done = ext_reg ? cst_rise
		: (sck_rise & (samp_cnt_reg == samp_len - 5'h01));
	wire conv_done = conv_tick & (conv_cnt_reg == CONV_SCLKS[6:0] - 7'h01);

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ASSC_IDLE:
				if (cst_fall | normal_go)
					state_next = ASSC_SAMPLE;
			ASSC_SAMPLE:
				if (samp_done)
					state_next = ASSC_CONVERT;
			ASSC_CONVERT:
				if (conv_done)
					state_next = ASSC_IDLE;
			default:
				state_next = ASSC_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ASSC_IDLE;
			samp_cnt_reg <= EDGE_CNT_RST;
			conv_cnt_reg <= CONV_CNT_RST;
			osc_cnt_reg <= OSC_CNT_RST;
			ext_reg <= 1'b0;
			result_reg <= RESULT_RST;
		end
		else
		begin
			state_reg <= state_next;
			osc_cnt_reg <= osc_cnt_reg + 2'h1;
			if (state_reg == ASSC_IDLE)
			begin
				ext_reg <= cst_fall;
				samp_cnt_reg <= EDGE_CNT_RST;
				conv_cnt_reg <= CONV_CNT_RST;
			end
			if (state_reg == ASSC_SAMPLE & sck_rise)
				samp_cnt_reg <= samp_cnt_reg + 5'h01;
			if (state_reg == ASSC_CONVERT & conv_tick)
				conv_cnt_reg <= conv_cnt_reg + 7'h01;
			// Analog result is modelled by the configured channel number at conversion end
			if (conv_done)
				result_reg <= {8'h00, cfg.channel};
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sampling <= 1'b0;
			converting <= 1'b0;
			mux_select <= 4'h0;
		end
		else
		begin
			sampling <= state_next == ASSC_SAMPLE;
			converting <= state_next == ASSC_CONVERT;
			// Codes 0-7 are inputs, 8-10 the self-test voltages
			if (state_reg == ASSC_IDLE)
				mux_select <= cfg.channel;
		end
	end

	// ****************************************************************
	// Result FIFO
	// ****************************************************************
	logic [FIFO_AW:0] wr_ptr_reg, rd_ptr_reg;
	wire fifo_full = fifo_level == 4'h8;
	wire fifo_pop = fifo_read & (fifo_level != 4'h0);
	wire fifo_push = conv_done & ~fifo_full;

	assc_result_mem u_mem
	(
		.clock(clock),
		.we(fifo_push),
		.waddr(wr_ptr_reg[FIFO_AW-1:0]),
		.wdata({8'h00, cfg.channel}),
		.raddr(rd_ptr_reg[FIFO_AW-1:0]),
		.rdata(fifo_rdata)
	);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg <= 4'h0;
			rd_ptr_reg <= 4'h0;
			fifo_level <= 4'h0;
			out_word_reg <= RESULT_RST;
		end
		else
		begin
			if (fifo_push)
				wr_ptr_reg <= wr_ptr_reg + 4'h1;
			if (fifo_pop)
				rd_ptr_reg <= rd_ptr_reg + 4'h1;
			fifo_level <= fifo_level + {3'h0, fifo_push} - {3'h0, fifo_pop};
			// Latch the output word at frame start so it is stable
			if (frame_start)
				out_word_reg <= fifo_pop ? fifo_rdata : result_reg;
		end
	end

endmodule

// *** testbench/assc_monitor.sv ***
// Port checker of the serial sampling control block
module assc_monitor
(
	input wire logic clock,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic conversion_start_n,
	input wire logic serial_out_oe_n,
	input wire logic word_valid,
	input wire logic sampling,
	input wire logic converting,
	input wire logic [3:0] mux_select,
	input wire logic [3:0] fifo_level
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	a_drive_on_select: assert property ($fell(chip_select_n) |->
		##[1:6] !serial_out_oe_n) else $error("output not driven");
	a_float_deselected: assert property (chip_select_n [*7] |->
		serial_out_oe_n) else $error("output driven while deselected");
	a_valid_one_pulse: assert property (word_valid |=>
		!word_valid) else $error("word pulse too long");
	a_float_after_word: assert property (word_valid |->
		##[0:3] serial_out_oe_n) else $error("output not released");
	a_pin_starts: assert property ($fell(conversion_start_n) &&
		!sampling && !converting |-> ##[1:6] sampling)
		else $error("pin fall did not start sampling");
	a_pin_converts: assert property ($rose(conversion_start_n) &&
		sampling |-> ##[1:6] converting)
		else $error("pin rise did not convert");
	a_hold_while_low: assert property
		((!conversion_start_n && sampling) [*4] |=> sampling)
		else $error("sampling ended while pin low");
	a_one_phase: assert property (!(sampling && converting))
		else $error("sampling and converting together");
	a_fifo_bound: assert property (fifo_level <= 4'h8)
		else $error("fifo level above depth");
	a_mux_range: assert property (mux_select <= 4'hA)
		else $error("mux select out of range");
endmodule

bind assc_top assc_monitor mon (.clock(clock), .rst(rst),
	.chip_select_n(chip_select_n), .conversion_start_n(conversion_start_n),
	.serial_out_oe_n(serial_out_oe_n), .word_valid(word_valid),
	.sampling(sampling), .converting(converting),
	.mux_select(mux_select), .fifo_level(fifo_level));

// *** testbench/assc_host_model.sv ***
// Host serial port model that runs frames into the block
module assc_host_model
(
	input wire logic clock,
	input wire logic serial_out_o,
	output logic chip_select_n,
	output logic serial_clk,
	output logic serial_in,
	output logic frame_sync
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		chip_select_n = 1'b1;
		serial_clk = 1'b0;
		serial_in = 1'b0;
		frame_sync = 1'b1;
	end

	task automatic hc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Clock stays low between frames; data line idles inverted
	task automatic xfer(input logic [15:0] w, input logic fs,
		input int n, output logic [15:0] rd);
		chip_select_n = 1'b0;
		hc(8);
		if (fs)
		begin
			frame_sync = 1'b0;
			hc(4);
			frame_sync = 1'b1;
			hc(4);
		end
		for (int i = 0; i < n; i++)
		begin
			if (!fs)
				serial_in = (i < 16) ? w[15 - i] : 1'b0;
			hc(4);
			if (!fs && i < 16) rd[15 - i] = serial_out_o;
			serial_clk = 1'b1;
			// Falling-edge capture: data moves on the rise, never on the fall
			if (fs)
				serial_in = (i < 16) ? w[15 - i] : 1'b0;
			hc(4);
			if (fs && i < 16) rd[15 - i] = serial_out_o;
			serial_clk = 1'b0;
		end
		hc(4);
		chip_select_n = 1'b1;
		serial_in = ~serial_in;
	endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench of the serial sampling control block
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
	import assc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic conversion_start_n = 1'b1;
	logic fifo_read = 1'b0;
	assc_cfg_s cfg = 6'h00;
	wire logic chip_select_n, serial_clk, serial_in, frame_sync, serial_out;
	logic serial_out_o, oe_n, word_valid, sampling, converting;
	assc_word_s word_out;
	logic [3:0] mux_select;
	logic [FIFO_AW:0] fifo_level;
	logic [15:0] rd;
	logic seen_valid = 1'b0;
	int n_mismatch = 0;
	int n_compared = 0;
	int scnt = 0;
	int ccnt = 0;

	assign serial_out = oe_n ? 1'bz : serial_out_o;
	always #10 clock = ~clock;
	always @(posedge clock) if (sampling === 1'b1) scnt++;
	always @(posedge clock) if (converting === 1'b1) ccnt++;
	always @(posedge clock) if (word_valid === 1'b1) seen_valid = 1'b1;

	assc_top dut (.clock(clock), .rst(rst), .chip_select_n(chip_select_n),
		.serial_clk(serial_clk), .serial_in(serial_in),
		.frame_sync(frame_sync), .conversion_start_n(conversion_start_n),
		.cfg(cfg), .fifo_read(fifo_read), .serial_out_o(serial_out_o),
		.serial_out_oe_n(oe_n), .word_out(word_out),
		.word_valid(word_valid), .sampling(sampling),
		.converting(converting), .mux_select(mux_select),
		.fifo_level(fifo_level));
	assc_host_model host (.clock(clock), .serial_out_o(serial_out),
		.chip_select_n(chip_select_n), .serial_clk(serial_clk),
		.serial_in(serial_in), .frame_sync(frame_sync));

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wait_idle;
		for (int k = 0; (sampling | converting) !== 1'b0 && k < 600; k++)
			cyc(1);
		`CHK("idle", 1'b0, sampling | converting)
	endtask

	task print_verdict;
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		cyc(10);
		rst = 1'b0;
		cyc(6);
		`CHK("oe_n", 1'b1, oe_n)
		`CHK("level", 4'h0, fifo_level)
		cfg.channel = 4'h5;
		cyc(4);
		`CHK("mux", 4'h5, mux_select)
		// Pin-driven sampling while deselected and serial clock idle
		conversion_start_n = 1'b0;
		cyc(8);
		`CHK("sampling", 1'b1, sampling)
		cyc(60);
		`CHK("hold", 1'b1, sampling)
		ccnt = 0;
		conversion_start_n = 1'b1;
		cyc(6);
		`CHK("convert", 1'b1, converting)
		wait_idle();
		`CHK("conv osc", 1'b1, ccnt > 283 && ccnt < 290)
		`CHK("level", 4'h1, fifo_level)
		scnt = 0;
		host.xfer(16'hA5C3, 1'b0, 16, rd);
		`CHK("sdo", 16'h0050, rd)
		`CHK("word", 16'hA5C3, word_out)
		wait_idle();
		`CHK("span", 1'b1, scnt > 91 && scnt < 101)
		`CHK("level", 4'h2, fifo_level)
		fifo_read = 1'b1;
		cyc(1);
		fifo_read = 1'b0;
		cyc(2);
		`CHK("pop", 4'h1, fifo_level)
		// Frame sync framing with surplus edges past the sixteenth
		cfg.channel = 4'hA;
		host.xfer(16'h3C96, 1'b1, 20, rd);
		`CHK("word", 16'h3C96, word_out)
		`CHK("sdo", 16'h0050, rd)
		`CHK("mux", 4'hA, mux_select)
		wait_idle();
		// Frame cut short before sampling would start
		seen_valid = 1'b0;
		host.xfer(16'hFFFF, 1'b0, 3, rd);
		cyc(8);
		`CHK("cut", 1'b0, seen_valid)
		`CHK("float", 1'b1, oe_n)
		// Long sampling, converted on the serial clock inside one long frame
		cfg.long_sample = 1'b1;
		cfg.sclk_conv_clk = 1'b1;
		scnt = 0;
		ccnt = 0;
		host.xfer(16'h1234, 1'b0, 110, rd);
		`CHK("sdo", 16'h00A0, rd)
		`CHK("word", 16'h1234, word_out)
		wait_idle();
		`CHK("span", 1'b1, scnt > 187 && scnt < 197)
		`CHK("conv sclk", 1'b1, ccnt > 570 && ccnt < 582)
		`CHK("level", 4'h3, fifo_level)
		print_verdict();
	end

	// Tests need about 2200 cycles; allow over four times that
	initial
	begin
		#200000;
		n_mismatch++;
		print_verdict();
	end
endmodule
